// ==== verilog/qsr_top.sv ====
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "qsr_defines.svh"

// ----------------------------------------------------------------
// Step queue
// ----------------------------------------------------------------
module qsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `QSR_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    assign level = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
        end
    end
endmodule

// ----------------------------------------------------------------
// Quad shift register with register access
// ----------------------------------------------------------------
module qsr_top #(
    parameter int LEN = `QSR_LEN_80,
    parameter bit BIDIR = 1'b1,
    parameter int FIFO_DEPTH = `QSR_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic shift_clk,
    input wire logic [3:0] data_in,
    input wire logic loop_ctrl_first_three,
    input wire logic loop_ctrl_fourth,
    input wire logic loop_in_fourth,
    input wire logic clear_all,
    input wire logic shift_direction,
    output logic [3:0] data_out
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int SW = $bits(qsr_pkg::qsr_step_t);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] ctrl_reg;
    logic [15:0] count_reg;
    logic req;
    logic step_wr;
    logic accept;
    logic q_in_ready;
    logic q_out_valid;
    logic q_out_ready;
    logic [SW-1:0] q_out_data;
    logic [LW-1:0] q_level;
    logic [31:0] rd_mux;
    logic [3:0] flag_bits;
    logic [3:0] out_bits;

    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign step_wr = wb_we_i & (wb_adr_i == `QSR_ADDR_STEP) & wb_sel_i[0];
    // A full queue withholds ack, so the writer stalls rather than losing steps
    assign accept = req & (~step_wr | q_in_ready);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            `QSR_ADDR_CTRL: begin
                rd_mux = ctrl_reg;
            end
            `QSR_ADDR_STATUS: begin
                rd_mux[`QSR_STAT_OUT_LSB +: 4] = out_bits;
                rd_mux[`QSR_STAT_FLAG_LSB +: 4] = flag_bits;
                rd_mux[`QSR_STAT_EMPTY] = ~q_out_valid;
                rd_mux[`QSR_STAT_FULL] = ~q_in_ready;
                rd_mux[`QSR_STAT_LEVEL_LSB +: LW] = q_level;
            end
            `QSR_ADDR_COUNT: begin
                rd_mux[15:0] = count_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= accept;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (accept & ~wb_we_i) begin
            rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= `QSR_CTRL_RESET;
        end else if (accept & wb_we_i & (wb_adr_i == `QSR_ADDR_CTRL) & wb_sel_i[0]) begin
            ctrl_reg <= {31'h0000_0000, wb_dat_i[`QSR_CTRL_PIN_EN]};
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    qsr_fifo #(
        .WIDTH(SW),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .mclk(mclk),
        .srst(srst),
        .in_valid(req & step_wr),
        .in_ready(q_in_ready),
        .in_data(wb_dat_i[SW-1:0]),
        .out_valid(q_out_valid),
        .out_ready(q_out_ready),
        .out_data(q_out_data),
        .level(q_level)
    );

    // ----------------------------------------------------------------
    // Step source
    // ----------------------------------------------------------------
    logic shift_clk_prev_reg;
    logic pin_step;
    logic step;
    qsr_pkg::qsr_step_t cur;
    qsr_pkg::qsr_step_t q_step;

    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_clk_prev_reg <= 1'b0;
        end else begin
            shift_clk_prev_reg <= shift_clk;
        end
    end

    // Only the rising edge of the pin shifts; a held pin keeps contents
    assign pin_step = ctrl_reg[`QSR_CTRL_PIN_EN] & shift_clk & ~shift_clk_prev_reg;
    assign q_step = qsr_pkg::qsr_step_t'(q_out_data);
    // Pin edges win the cycle; the queue waits, and clear freezes it too
    assign q_out_ready = ~pin_step & ~clear_all;
    assign step = ~clear_all & (pin_step | q_out_valid);

    always_comb begin
        if (pin_step) begin
            cur.din = data_in;
            cur.loop_ctrl_first_three = loop_ctrl_first_three;
            cur.loop_ctrl_fourth = loop_ctrl_fourth;
            cur.loop_in_fourth = loop_in_fourth;
            cur.dir = shift_direction;
        end else begin
            cur = q_step;
        end
        // Fixed-direction build ignores the control
        if (!BIDIR) begin
            cur.dir = qsr_pkg::QSR_DIR_RIGHT;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            count_reg <= 16'h0000;
        end else if (step) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Four registers
    // ----------------------------------------------------------------
    // Position 0 is the input end, position LEN-1 the output end
    for (genvar g = 0; g < 4; g++) begin : g_ch
        logic [LEN-1:0] sr_reg;
        logic [LEN-1:0] sr_next;
        logic out_reg;
        logic feed;
        logic left;

        assign left = (cur.dir == qsr_pkg::QSR_DIR_LEFT);

        always_comb begin
            if (g < 3) begin
                // Loop takes the bit that leaves this step
                feed = cur.loop_ctrl_first_three ? (left ? sr_reg[0] : sr_reg[LEN-1]) : cur.din[g];
            end else begin
                feed = cur.loop_ctrl_fourth ? cur.loop_in_fourth : cur.din[g];
            end
        end

        always_comb begin
            sr_next = sr_reg;
            for (int i = 0; i < LEN; i++) begin
                if (left) begin
                    sr_next[i] = (i == LEN - 1) ? feed : sr_reg[(i + 1) % LEN];
                end else begin
                    sr_next[i] = (i == 0) ? feed : sr_reg[(i + LEN - 1) % LEN];
                end
            end
        end

        always_ff @(posedge mclk) begin
            if (srst | clear_all) begin
                sr_reg <= '0;
            end else if (step) begin
                sr_reg <= sr_next;
            end
        end

        // Left shift pops the newest bit; right shift shows the output end
        always_ff @(posedge mclk) begin
            if (srst | clear_all) begin
                out_reg <= 1'b0;
            end else if (step) begin
                out_reg <= left ? sr_reg[0] : sr_next[LEN-1];
            end
        end

        assign out_bits[g] = out_reg;
        assign flag_bits[g] = sr_reg[LEN-1];
    end

    assign data_out = out_bits;
endmodule

// ==== verilog/qsr_defines.svh ====
`ifndef QSR_DEFINES_SVH
`define QSR_DEFINES_SVH

// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define QSR_LEN_80 80
`define QSR_LEN_81 81
`define QSR_LEN_133 133
`define QSR_LEN_MIN 1
`define QSR_LEN_MAX 134

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define QSR_ADDR_CTRL 8'h00
`define QSR_ADDR_STEP 8'h04
`define QSR_ADDR_STATUS 8'h08
`define QSR_ADDR_COUNT 8'h0c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define QSR_CTRL_PIN_EN 0
`define QSR_CTRL_RESET 32'h0000_0001
`define QSR_STAT_OUT_LSB 0
`define QSR_STAT_FLAG_LSB 4
`define QSR_STAT_EMPTY 8
`define QSR_STAT_FULL 9
`define QSR_STAT_LEVEL_LSB 10

// ----------------------------------------------------------------
// Queue
// ----------------------------------------------------------------
`define QSR_FIFO_DEPTH 32

`endif

// ==== verilog/qsr_pkg.sv ====
package qsr_pkg;

    // ----------------------------------------------------------------
    // One shift step: four data bits plus the controls for that step
    // ----------------------------------------------------------------
    typedef struct packed {
        logic dir;
        logic loop_in_fourth;
        logic loop_ctrl_fourth;
        logic loop_ctrl_first_three;
        logic [3:0] din;
    } qsr_step_t;

    typedef enum logic {
        QSR_DIR_RIGHT = 1'b0,
        QSR_DIR_LEFT = 1'b1
    } qsr_dir_t;

endpackage

// ==== dv/qsr_top_chk.sv ====
`timescale 1ns/100ps
// ----------
// Port checker
// ----------
module qsr_top_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic shift_clk,
    input wire logic clear_all,
    input wire logic [3:0] data_out
);
    logic clk_d;
    logic step_d;
    logic seen_reg;
    always_ff @(posedge mclk) begin
        clk_d <= shift_clk;
        step_d <= shift_clk & ~clk_d;
    end
    // Queued steps move outputs too, so the cause check stops at the first
    always_ff @(posedge mclk) begin
        if (srst)
            seen_reg <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h04)
            seen_reg <= 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    clear_low_a: assert property (clear_all |=> data_out == 4'h0)
        else $error("outputs not cleared");
    clear_wins_a: assert property (clear_all [*2] |=> $stable(data_out))
        else $error("outputs moved under clear");
    out_cause_a: assert property (!$stable(data_out) && !seen_reg |-> step_d || $past(clear_all))
        else $error("outputs moved without step");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    ack_soon_a: assert property ($rose(wb_cyc_i && wb_stb_i) && !(wb_we_i && wb_adr_i == 8'h04) |=> wb_ack_o)
        else $error("ack late");
    unmap_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h10) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    status_out_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h08)
        |-> wb_dat_o[3:0] == $past(data_out)) else $error("status outputs wrong");
    cover property (step_d);
    cover property (clear_all [*2]);
    cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h04);
endmodule

bind qsr_top qsr_top_chk chk (.mclk, .srst, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .shift_clk, .clear_all, .data_out);

// ==== dv/qsr_host_model.sv ====
`timescale 1ns/100ps
// ----------
// Pin controller
// ----------
module qsr_host_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic go,
    input wire qsr_pkg::qsr_step_t step,
    output logic shift_clk = 1'b0,
    output qsr_pkg::qsr_step_t pins = 8'h00
);
    logic [1:0] phase = 2'h0;
    always @(posedge mclk) begin
        if (srst || phase == 2'h2) begin
            phase <= 2'h0;
            shift_clk <= 1'b0;
            pins.loop_ctrl_fourth <= 1'b0;
        end else if (phase == 2'h1) begin
            shift_clk <= 1'b1;
            phase <= 2'h2;
        end else if (go) begin
            pins <= step;
            phase <= 2'h1;
        end else begin
            // Idle data lines wander, never a stale copy
            pins.din <= ~pins.din;
        end
    end
endmodule

// ==== dv/quad_recirculating_shift_register_bench.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin \
    check_count++; \
    if ((s) !== (e)) begin \
        err_total++; \
        $display("BAD %s exp %h got %h", n, e, s); \
    end \
end
module quad_recirculating_shift_register_bench;
    localparam int L = 5;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h1;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic clear_all = 1'b0;
    logic go = 1'b0;
    qsr_pkg::qsr_step_t step = 8'h00;
    qsr_pkg::qsr_step_t pins;
    qsr_pkg::qsr_step_t qd [$];
    logic wb_ack_o, shift_clk, loop_ctrl_first_three, loop_ctrl_fourth, loop_in_fourth, shift_direction;
    logic [3:0] data_in, data_out, fixed_out;
    logic [3:0] exp_out [2];
    logic [31:0] q, r, wb_dat_o;
    logic [L-1:0] sr [2][4];
    int err_total = 0;
    int check_count = 0;
    int cnt = 0;
    int seed = 32'h119bd514;
    assign {shift_direction, loop_in_fourth, loop_ctrl_fourth, loop_ctrl_first_three, data_in} = pins;
    always #20 mclk = ~mclk;
    qsr_top #(.LEN(L)) dut (.mclk, .srst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
        .wb_ack_o, .wb_dat_o, .shift_clk, .data_in, .loop_ctrl_first_three, .loop_ctrl_fourth,
        .loop_in_fourth, .clear_all, .shift_direction, .data_out);
    qsr_host_model host (.mclk, .srst, .go, .step, .shift_clk, .pins);
    // Fixed-direction build on the same pins and bus; only its outputs are watched
    qsr_top #(.LEN(L), .BIDIR(1'b0)) dut_fixed (.mclk, .srst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
        .wb_stb_i, .wb_ack_o(), .wb_dat_o(), .shift_clk, .data_in, .loop_ctrl_first_three, .loop_ctrl_fourth,
        .loop_in_fourth, .clear_all, .shift_direction, .data_out(fixed_out));
    // ----------
    // Expectations
    // ----------
    function automatic void apply(qsr_pkg::qsr_step_t s);
        logic f;
        for (int m = 0; m < 2; m++) begin
            // Second copy is the fixed-direction build: direction is ignored
            if (m == 1)
                s.dir = 1'b0;
            for (int i = 0; i < 4; i++) begin
                f = s.din[i];
                if (i < 3 && s.loop_ctrl_first_three)
                    f = s.dir ? sr[m][i][0] : sr[m][i][L-1];
                if (i == 3 && s.loop_ctrl_fourth)
                    f = s.loop_in_fourth;
                exp_out[m][i] = sr[m][i][0];
                sr[m][i] = s.dir ? {f, sr[m][i][L-1:1]} : {sr[m][i][L-2:0], f};
                if (!s.dir)
                    exp_out[m][i] = sr[m][i][L-1];
            end
        end
        cnt++;
    endfunction
    function automatic void wipe();
        foreach (sr[m, i]) sr[m][i] = '0;
        foreach (exp_out[m]) exp_out[m] = 4'h0;
    endfunction
    // ----------
    // Drivers
    // ----------
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input int rel);
        int n;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n == rel)
                clear_all <= 1'b0;
        end while (wb_ack_o !== 1'b1 && n < 300);
        if (rel > 0)
            `CHK("stall", 1'b1, n > rel)
        if (n >= 300)
            err_total++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic pin(input qsr_pkg::qsr_step_t s, input logic en);
        @(posedge mclk);
        step <= s;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (4) @(posedge mclk);
        if (en)
            apply(s);
        `CHK("data_out", exp_out[0], data_out)
        `CHK("fixed_out", exp_out[1], fixed_out)
    endtask
    task automatic stat(input logic [5:0] lvl);
        logic [3:0] last;
        for (int i = 0; i < 4; i++) last[i] = sr[0][i][L-1];
        bus(1'b0, 8'h08, 32'h0, 0);
        `CHK("status", {lvl, (lvl == 6'h20), (lvl == 6'h00), last, exp_out[0]}, q[15:0])
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
    initial begin
        wipe();
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        stat(6'h00);
        bus(1'b0, 8'h00, 32'h0, 0);
        `CHK("ctrl", 32'h1, q)
        bus(1'b1, 8'h10, 32'hffff_ffff, 0);
        bus(1'b0, 8'h10, 32'h0, 0);
        `CHK("unmapped", 32'h0, q)
        $display("registers done");
        // First sixteen steps walk every loop and direction combination
        for (int k = 0; k < 56; k++) begin
            r = $random(seed);
            if (k < 16)
                r[7:4] = k[3:0];
            pin(r[7:0], 1'b1);
        end
        stat(6'h00);
        bus(1'b0, 8'h0c, 32'h0, 0);
        `CHK("count", cnt[15:0], q[15:0])
        repeat (60) @(posedge mclk);
        stat(6'h00);
        bus(1'b1, 8'h00, 32'h0, 0);
        pin(r[7:0], 1'b0);
        bus(1'b1, 8'h00, 32'h1, 0);
        $display("shifting done");
        @(posedge mclk);
        clear_all <= 1'b1;
        wipe();
        pin(~r[7:0], 1'b0);
        for (int k = 0; k < 33; k++) begin
            r = $random(seed);
            qd.push_back(r[7:0]);
            if (k == 32)
                stat(6'h20);
            bus(1'b1, 8'h04, r, (k == 32) ? 10 : 0);
        end
        repeat (60) @(posedge mclk);
        while (qd.size() > 0) apply(qd.pop_front());
        stat(6'h00);
        $display("queue done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        wipe();
        stat(6'h00);
        for (int k = 0; k < 8; k++) pin(8'($random(seed)), 1'b1);
        $display("reset done");
        report_and_stop();
    end
endmodule
